// ### core/crosspoint_route_loader.sv
// module: device end, two-rank route latches and switch decode
//
// Function
// - reset low disables all nine switch outputs asynchronously; the common mode pass output is not disabled
// - reset leaves the shift register untouched
// - broadcast copies route code everywhere
// - loads touch first rank only
// - serial mode shifts data in each clock
// - chain output is bit from 45 serial shifts ago
// - parallel writes route code at output index
// - update copies first rank to second rank
// - chip select gates loads and update
// - reset clears second rank only
// - each output selects one input or none
// - controller shifts whole register in serial
`timescale 1ns/1ps
module crosspoint_route_loader (
    // clock and reset
    input  wire logic                clock_in,
    input  wire logic                srst_in,
    // control pins
    route_loader_if.device           pins,
    // switch array drive
    output logic [8:0]               output_enable_out,
    output logic [8:0][15:0]         input_connect_out,
    output logic                     common_mode_pass_out
);
    localparam int N = route_loader_pkg::CHAIN_LEN;
    localparam int W = route_loader_pkg::FIELD_W;

    // =========================================
    // operating notes
    // the block keeps two ranks of route data. the first rank is a
    // 45-bit shift register that the controller fills; the second rank
    // holds the image that actually drives the switch array.
    //
    // three ways fill the first rank, each picked by the strobe levels
    // seen at a clock edge while chip select is low:
    //   serial    - one bit a clock, oldest bit leaving on the chain pin
    //   parallel  - one 5-bit field, chosen by the output index
    //   broadcast - the same 5-bit code copied into all nine fields
    // none of them touches the second rank, so the outputs never show a
    // half-written image; the update strobe moves all nine fields at once.
    //
    // the reset pin works on two paths. the enable mask reacts at once,
    // with no clock, so outputs drop even if the clock has stopped. the
    // second rank is also cleared at the next edge, so the outputs stay
    // off once the pin is released until a fresh update arrives.
    // the first rank is left alone by both resets: a controller may load
    // it before the reset pin goes low and update straight after release; loads are ignored while the pin is low.
    //
    // limitations a user must know:
    //   - a parallel index of nine or more is dropped without a trace
    //   - serial loads cannot patch one field; the whole 45 bits go in
    //   - the chain pin moves only on serial shift edges, so it keeps
    //     the last bit pushed out while other loads run
    //   - the first rank powers up unknown; load it before any update
    //
    // hazards avoided:
    //   - reset on the pin is also sampled at the edge, so the clocked
    //     and the unclocked views of the outputs agree afterwards
    //   - the chain flop is cleared by the block reset only, so a cascade
    //     never passes an unknown bit down before its first frame
    //   - decode uses levels seen at one edge; strobes that change between
    //     edges have no effect of their own
    //   - chip select low is part of every load and update term, so a
    //     deselected device ignores traffic meant for its neighbours
    //
    // trade-off: the enable mask stays combinational so that the reset
    // pin needs no clock; the connect lines follow the mask, the common mode output passes its pin straight through, the rest come from flops.
    //
    // field layout, per output o:
    //   bit 5o+4      output enable
    //   bits 5o+3..5o input number, 0 to 15

    // =========================================
    // field helpers, shared by the load path and the switch decode
    // enable bit of output o within a whole image
    function automatic logic field_enable(input logic [N-1:0] img, input int o);
        return img[o*W + route_loader_pkg::ENABLE_BIT];
    endfunction : field_enable

    // input number of output o within a whole image
    function automatic logic [3:0] field_select(input logic [N-1:0] img, input int o);
        return img[o*W +: route_loader_pkg::SEL_W];
    endfunction : field_select

    // one-hot drive for a single input; all zero is never produced here
    function automatic logic [15:0] one_hot(input logic [3:0] sel);
        logic [15:0] hot;
        hot = 16'h0;
        hot[sel] = 1'b1;
        return hot;
    endfunction : one_hot

    // indices past the last output address nothing and are refused
    function automatic logic index_in_range(input logic [3:0] idx);
        return idx < 4'(route_loader_pkg::OUTPUTS);
    endfunction : index_in_range

    // image with one field replaced, the rest kept
    function automatic logic [N-1:0] place_field(input logic [N-1:0] img, input logic [3:0] idx,
                                                 input logic [W-1:0] code);
        logic [N-1:0] merged;
        merged = img;
        merged[idx*W +: W] = code;
        return merged;
    endfunction : place_field

    logic [N-1:0] shift_reg;
    logic [N-1:0] shift_next;
    logic [N-1:0] latch_reg;
    logic         chain_reg;

    // =========================================
    // pin decode
    logic sel_active;
    logic do_serial;
    logic do_broadcast;
    logic do_parallel;
    logic do_update;
    assign sel_active   = pins.reset_n && !pins.chip_select_n;
    assign do_serial    = sel_active && pins.write_strobe_n && pins.update_strobe_n && !pins.load_style_select;
    assign do_broadcast = sel_active && !pins.write_strobe_n && pins.update_strobe_n
                          && !pins.load_style_select;
    assign do_parallel  = sel_active && !pins.write_strobe_n && pins.update_strobe_n
                          && pins.load_style_select;
    assign do_update    = sel_active && pins.write_strobe_n && !pins.update_strobe_n;

    // the strobe combinations exclude each other, so the chain order sets no priority;
    // naming the operation keeps the first rank update a plain case
    route_loader_pkg::host_cmd_e op_now;
    always_comb begin
        if (do_serial) begin
            op_now = route_loader_pkg::CMD_SERIAL;
        end else if (do_broadcast) begin
            op_now = route_loader_pkg::CMD_BROADCAST;
        end else if (do_parallel) begin
            op_now = route_loader_pkg::CMD_PARALLEL;
        end else if (do_update) begin
            op_now = route_loader_pkg::CMD_UPDATE;
        end else begin
            op_now = route_loader_pkg::CMD_IDLE;
        end
    end

    // =========================================
    // first rank next value; index beyond field 8 is ignored
    always_comb begin
        shift_next = shift_reg;
        case (op_now)
            route_loader_pkg::CMD_SERIAL: begin
                shift_next = {shift_reg[N-2:0], pins.shift_data_in};
            end
            route_loader_pkg::CMD_BROADCAST: begin
                shift_next = {route_loader_pkg::OUTPUTS{pins.route_code_bits}};
            end
            route_loader_pkg::CMD_PARALLEL: begin
                if (index_in_range(pins.output_index_bits)) begin
                    shift_next = place_field(shift_reg, pins.output_index_bits, pins.route_code_bits);
                end
            end
            default: begin
                shift_next = shift_reg;
            end
        endcase
    end

    // first rank never sees reset, so contents survive it
    always_ff @(posedge clock_in) begin
        shift_reg <= shift_next;
    end

    // chain output: the bit falling off the end, 45 shifts after entry
    // block reset gives the chain a known level before the first frame
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            chain_reg <= 1'b0;
        end else if (do_serial) begin
            chain_reg <= shift_reg[N-1];
        end
    end
    assign pins.chain_data_out = chain_reg;

    // =========================================
    // second rank; reset clears it, sampled here as the disable request
    always_ff @(posedge clock_in) begin
        if (srst_in || !pins.reset_n) begin
            latch_reg <= route_loader_pkg::LATCH_RESET;
        end else if (do_update) begin
            latch_reg <= shift_reg;
        end
    end

    // =========================================
    // switch decode; reset pin masks enables immediately, not waiting a clock
    always_comb begin
        for (int o = 0; o < route_loader_pkg::OUTPUTS; o++) begin
            output_enable_out[o] = field_enable(latch_reg, o) && pins.reset_n;
            input_connect_out[o] = 16'h0;
            if (output_enable_out[o]) begin
                input_connect_out[o] = one_hot(field_select(latch_reg, o));
            end
        end
    end
    assign common_mode_pass_out = pins.common_mode_pass_select;
endmodule : crosspoint_route_loader

// ### common/route_loader_pkg.sv
// package: constants shared by the crosspoint route loader ends
package route_loader_pkg;
    // =========================================
    // geometry
    localparam int OUTPUTS     = 9;
    localparam int INPUTS      = 16;
    localparam int FIELD_W     = 5;
    localparam int SEL_W       = 4;
    localparam int CHAIN_LEN   = OUTPUTS * FIELD_W;   // 45-bit first rank
    localparam int ENABLE_BIT  = 4;                   // field bit 4 enables the output
    // =========================================
    // reset values
    localparam logic [44:0] LATCH_RESET = 45'h0;
    localparam logic [5:0]  COUNT_RESET = 6'h0;
    // =========================================
    // host command encoding
    typedef enum logic [2:0] {
        CMD_IDLE      = 3'b000,
        CMD_SERIAL    = 3'b001,
        CMD_PARALLEL  = 3'b010,
        CMD_BROADCAST = 3'b011,
        CMD_UPDATE    = 3'b100
    } host_cmd_e;
endpackage : route_loader_pkg

// ### common/route_loader_if.sv
// interface: control pins between controller and crosspoint loader
`timescale 1ns/1ps
interface route_loader_if;
    logic       reset_n;             // active low, disables outputs
    logic       chip_select_n;
    logic       write_strobe_n;
    logic       update_strobe_n;
    logic       load_style_select;   // 0 serial/broadcast, 1 parallel
    logic       shift_data_in;
    logic [4:0] route_code_bits;
    logic [3:0] output_index_bits;
    logic       common_mode_pass_select;
    logic       chain_data_out;
    modport device (input reset_n, chip_select_n, write_strobe_n, update_strobe_n, load_style_select,
                    shift_data_in, route_code_bits, output_index_bits, common_mode_pass_select,
                    output chain_data_out);
    modport host (output reset_n, chip_select_n, write_strobe_n, update_strobe_n, load_style_select,
                  shift_data_in, route_code_bits, output_index_bits, common_mode_pass_select,
                  input chain_data_out);
endinterface : route_loader_if

// ### core/route_loader_host.sv
// module: controller end driving the crosspoint control pins
`timescale 1ns/1ps
module route_loader_host (
    // clock and reset
    input  wire logic                clock_in,
    input  wire logic                srst_in,
    // user command
    input  wire logic                cmd_valid_in,
    input  wire logic [2:0]          cmd_in,
    input  wire logic [44:0]         image_in,
    input  wire logic [4:0]          code_in,
    input  wire logic [3:0]          index_in,
    input  wire logic                cm_pass_in,
    input  wire logic                disable_in,
    output logic                     busy_out,
    output logic                     chain_seen_out,
    // control pins
    route_loader_if.host             pins
);
    localparam int N = route_loader_pkg::CHAIN_LEN;

    logic [N-1:0] image_reg;
    logic [5:0]   count_reg;
    logic [2:0]   cmd_reg;
    logic         cs_n_reg, we_n_reg, upd_n_reg, style_reg, data_reg, rst_n_reg, cm_reg, seen_reg;
    logic [4:0]   code_reg;
    logic [3:0]   index_reg;

    // =========================================
    // sequencer; serial always sends the whole image
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            cmd_reg <= route_loader_pkg::CMD_IDLE;
            count_reg <= route_loader_pkg::COUNT_RESET;
            image_reg <= route_loader_pkg::LATCH_RESET;
            cs_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            upd_n_reg <= 1'b1;
            style_reg <= 1'b0;
            data_reg <= 1'b0;
            code_reg <= 5'h0;
            index_reg <= 4'h0;
            busy_out <= 1'b0;
        end else if (busy_out && cmd_reg == route_loader_pkg::CMD_SERIAL && count_reg != 6'h0) begin
            data_reg <= image_reg[N-1];
            image_reg <= {image_reg[N-2:0], 1'b0};
            count_reg <= count_reg - 6'h1;
        end else if (busy_out) begin
            cs_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            upd_n_reg <= 1'b1;
            busy_out <= 1'b0;
        end else if (cmd_valid_in) begin
            cmd_reg <= cmd_in;
            busy_out <= 1'b1;
            cs_n_reg <= 1'b0;
            code_reg <= code_in;
            index_reg <= index_in;
            style_reg <= (cmd_in == route_loader_pkg::CMD_PARALLEL);
            we_n_reg <= !(cmd_in == route_loader_pkg::CMD_PARALLEL ||
                          cmd_in == route_loader_pkg::CMD_BROADCAST);
            upd_n_reg <= !(cmd_in == route_loader_pkg::CMD_UPDATE);
            if (cmd_in == route_loader_pkg::CMD_SERIAL) begin
                cs_n_reg <= 1'b1;
                image_reg <= {image_in[N-2:0], 1'b0};
                data_reg <= image_in[N-1];
                count_reg <= 6'(N);
            end
        end
    end

    // chip select for serial asserted while bits are presented
    logic cs_serial;
    assign cs_serial = busy_out && cmd_reg == route_loader_pkg::CMD_SERIAL && count_reg != 6'h0;

    // reset pin and mode pass-through, registered
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rst_n_reg <= 1'b0;
            cm_reg <= 1'b0;
            seen_reg <= 1'b0;
        end else begin
            rst_n_reg <= !disable_in;
            cm_reg <= cm_pass_in;
            seen_reg <= pins.chain_data_out;
        end
    end
    assign chain_seen_out = seen_reg;

    assign pins.reset_n                 = rst_n_reg;
    assign pins.chip_select_n           = cs_n_reg && !cs_serial;
    assign pins.write_strobe_n          = we_n_reg;
    assign pins.update_strobe_n         = upd_n_reg;
    assign pins.load_style_select       = style_reg;
    assign pins.shift_data_in           = data_reg;
    assign pins.route_code_bits         = code_reg;
    assign pins.output_index_bits       = index_reg;
    assign pins.common_mode_pass_select = cm_reg;
endmodule : route_loader_host

// ### test/route_loader_props.sv
// checker: pin-level properties of the route loader link
`timescale 1ns/1ps
module route_loader_props (
    // clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // control pins
    input wire logic reset_n,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic update_strobe_n,
    input wire logic load_style_select,
    input wire logic shift_data_in,
    input wire logic chain_data_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // =========================================
    // shift decode, bit history, shift total and frame length
    wire logic shift_now = reset_n && !chip_select_n && write_strobe_n && update_strobe_n && !load_style_select;
    logic [45:0] hist_reg;
    logic [5:0] count_reg;
    logic [5:0] run_reg;
    always_ff @(posedge clock_in) begin
        if (shift_now) hist_reg <= {hist_reg[44:0], shift_data_in};
    end
    // saturates at 45 so every later shift is judged
    always_ff @(posedge clock_in) begin
        if (srst_in) count_reg <= 6'h0;
        else if (shift_now && count_reg != 6'h2d) count_reg <= count_reg + 6'h1;
    end
    always_ff @(posedge clock_in) begin
        run_reg <= (srst_in || !shift_now) ? 6'h0 : run_reg + 6'h1;
    end
    // =========================================
    // assertions
    chk_chain_delay: assert property (shift_now && count_reg == 6'h2d |=> chain_data_out == hist_reg[45])
        else $error("chain output wrong");
    chk_chain_holds: assert property (!shift_now |=> $stable(chain_data_out))
        else $error("chain moved without shift");
    chk_frame_held: assert property ($fell(chip_select_n) && shift_now |-> shift_now [*8])
        else $error("serial frame broken");
    chk_frame_length: assert property (!shift_now && $past(shift_now) |-> run_reg == 6'h2d)
        else $error("serial frame not 45 bits");
    chk_update_single: assert property (!update_strobe_n |=> update_strobe_n)
        else $error("update strobe too long");
    chk_update_alone: assert property (!update_strobe_n |-> write_strobe_n && !chip_select_n && reset_n)
        else $error("update mixed with load");
    chk_load_single: assert property (!write_strobe_n |=> write_strobe_n)
        else $error("load strobe too long");
    chk_load_selected: assert property (!write_strobe_n |-> !chip_select_n && update_strobe_n)
        else $error("load outside select");
    cover property (run_reg == 6'h2d);
    cover property (!update_strobe_n);
    cover property (!write_strobe_n && load_style_select);
    cover property (!write_strobe_n && !load_style_select);
endmodule : route_loader_props

// ### test/crosspoint_route_loader_tb.sv
// testbench: host end drives the crosspoint end over the pins
`timescale 1ns/1ps
module crosspoint_route_loader_tb;
    // =========================================
    // signals
    logic clock_in;
    logic srst_in;
    logic valid;
    logic [2:0] cmd;
    logic [44:0] image;
    logic [4:0] code;
    logic [3:0] index;
    logic dis;
    logic busy;
    logic seen;
    logic cm;
    logic cm_out;
    logic [8:0] enable;
    logic [8:0][15:0] connect;
    logic [44:0] last_img;
    int err_total;
    int cmp_count;
    int cycles;
    route_loader_if pins ();
    route_loader_host route_loader_host_i (.clock_in(clock_in), .srst_in(srst_in), .cmd_valid_in(valid),
        .cmd_in(cmd), .image_in(image), .code_in(code), .index_in(index), .cm_pass_in(cm),
        .disable_in(dis), .busy_out(busy), .chain_seen_out(seen), .pins(pins));
    crosspoint_route_loader crosspoint_route_loader_i (.clock_in(clock_in), .srst_in(srst_in), .pins(pins),
        .output_enable_out(enable), .input_connect_out(connect), .common_mode_pass_out(cm_out));
    route_loader_props route_loader_props_i (.clock_in(clock_in), .srst_in(srst_in), .reset_n(pins.reset_n),
        .chip_select_n(pins.chip_select_n), .write_strobe_n(pins.write_strobe_n),
        .update_strobe_n(pins.update_strobe_n), .load_style_select(pins.load_style_select),
        .shift_data_in(pins.shift_data_in), .chain_data_out(pins.chain_data_out));
    task automatic fail(input string m);
        $display("ERROR %0t %s", $time, m);
        err_total++;
    endtask : fail
    // one command, then wait for idle and let the outputs settle
    task automatic issue(input route_loader_pkg::host_cmd_e c, input logic [44:0] i = 45'h0,
                         input logic [4:0] d = 5'h0, input logic [3:0] x = 4'h0);
        int n;
        @(posedge clock_in);
        valid <= 1'b1;
        cmd <= c;
        image <= i;
        code <= d;
        index <= x;
        @(posedge clock_in);
        valid <= 1'b0;
        @(posedge clock_in);
        #1;
        for (n = 0; n < 100 && busy !== 1'b0; n++) begin
            @(posedge clock_in);
            #1;
        end
        if (busy !== 1'b0) fail("host stuck busy");
        repeat (2) @(posedge clock_in);
        #1;
    endtask : issue
    // field o: bit 5o+4 enables, bits 5o+3..5o pick the input
    task automatic expect_image(input logic [44:0] g);
        logic [15:0] hot;
        for (int o = 0; o < 9; o++) begin
            hot = g[5*o+4] ? 16'h1 << g[5*o+:4] : 16'h0;
            cmp_count++;
            if (enable[o] !== g[5*o+4] || connect[o] !== hot) fail("switch drive differs");
        end
    endtask : expect_image
    task automatic t_broadcast_parallel();
        issue(route_loader_pkg::CMD_BROADCAST, 45'h0, 5'h13);
        expect_image(45'h0);
        issue(route_loader_pkg::CMD_UPDATE);
        expect_image({9{5'h13}});
        last_img = {9{5'h13}};
        last_img[14:10] = 5'h05;
        issue(route_loader_pkg::CMD_PARALLEL, 45'h0, 5'h05, 4'h2);
        issue(route_loader_pkg::CMD_PARALLEL, 45'h0, 5'h1f, 4'h9);
        issue(route_loader_pkg::CMD_UPDATE);
        expect_image(last_img);
        $display("test broadcast_parallel done");
    endtask : t_broadcast_parallel
    // the second frame pushes the first frame out through the chain
    task automatic t_serial();
        issue(route_loader_pkg::CMD_SERIAL, {9{5'h0b}});
        issue(route_loader_pkg::CMD_SERIAL, {1'b1, 4'hf, 1'b1, 4'he, 1'b1, 4'hd, {6{1'b1, 4'h7}}});
        expect_image(last_img);
        cmp_count++;
        if (seen !== 1'b1) fail("chain output not last bit of older frame");
        last_img = {1'b1, 4'hf, 1'b1, 4'he, 1'b1, 4'hd, {6{1'b1, 4'h7}}};
        issue(route_loader_pkg::CMD_UPDATE);
        expect_image(last_img);
        $display("test serial done");
    endtask : t_serial
    task automatic t_reset_pin();
        @(posedge clock_in);
        dis <= 1'b1;
        cm <= 1'b1;
        repeat (2) @(posedge clock_in);
        #1;
        expect_image(45'h0);
        cmp_count++;
        if (cm_out !== 1'b1) fail("mode pass select not passed through");
        @(posedge clock_in);
        dis <= 1'b0;
        issue(route_loader_pkg::CMD_UPDATE);
        expect_image(last_img);
        $display("test reset_pin done");
    endtask : t_reset_pin
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // =========================================
    // clock, watchdog and main sequence
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        srst_in = 1'b1;
        valid = 1'b0;
        cmd = 3'h0;
        image = 45'h0;
        code = 5'h0;
        index = 4'h0;
        dis = 1'b0;
        cm = 1'b0;
        repeat (16) @(posedge clock_in);
        srst_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
        expect_image(45'h0);
        t_broadcast_parallel();
        t_serial();
        t_reset_pin();
        tally_and_finish();
    end
endmodule : crosspoint_route_loader_tb
